// File: pkg/dpc_map.vh
`ifndef DPC_MAP_VH
`define DPC_MAP_VH
// system clock rate and timing
`define DPC_CLK_MHZ          125
`define DPC_CONFIG_LOAD_MS   100
`define DPC_CONFIG_LOAD_CYC  (`DPC_CONFIG_LOAD_MS * 1000 * `DPC_CLK_MHZ)
// serial target address
`define DPC_TARGET_ADDR      7'h3E
// register map of the serial port
`define DPC_REG_COUNT        8
`define DPC_REG_CMD          8'hF0
`define DPC_REG_STATUS       8'hF1
// reset values loaded from non-volatile store
`define DPC_DFLT_REG0        8'h11
`define DPC_DFLT_OTHER       8'h00
// command codes written to the command register
`define DPC_CMD_ON_START     8'h01
`define DPC_CMD_ON_FINAL     8'h05
`define DPC_CMD_OFF          8'h02
`define DPC_CMD_SLEEP        8'h03
`define DPC_CMD_WAKE         8'h04
`endif

// File: src/dpc_serial_target.v
`default_nettype none
`include "dpc_map.vh"

module dpc_serial_target
(
  // clock and reset
  input  wire       sys_clk,
  input  wire       srst,
  // synchronised bus lines and enable
  input  wire       sclSync,
  input  wire       sdaSync,
  input  wire       portEnable,
  // register access
  input  wire [7:0] rdData,
  output wire [7:0] rdAddr,
  output reg        wrStrobe,
  output reg  [7:0] wrAddr,
  output reg  [7:0] wrData,
  // data line drive
  output reg        sdaOe
);

  localparam [4:0] S_IDLE  = 5'h01;
  localparam [4:0] S_RX    = 5'h02;
  localparam [4:0] S_ACK   = 5'h04;
  localparam [4:0] S_TX    = 5'h08;
  localparam [4:0] S_TXACK = 5'h10;

  reg  [4:0] state;
  reg  [3:0] bitCnt;
  reg  [7:0] shiftReg;
  reg  [1:0] byteIdx;
  reg        readMode;
  reg  [7:0] regPtr;
  reg        sclPrev;
  reg        sdaPrev;
  wire       sclRise = sclSync & ~sclPrev;
  wire       sclFall = ~sclSync & sclPrev;
  wire       startSeen = sclSync & sclPrev & sdaPrev & ~sdaSync;
  wire       stopSeen = sclSync & sclPrev & ~sdaPrev & sdaSync;

  assign rdAddr = regPtr;

  ////////////////////////////////////////////////////////////////////////
  // byte engine, sampled on the system clock
  always @(posedge sys_clk)
  begin
    sclPrev  <= sclSync;
    sdaPrev  <= sdaSync;
    wrStrobe <= 1'b0;
    if (srst)
    begin
      state    <= S_IDLE;
      bitCnt   <= 4'h0;
      shiftReg <= 8'h00;
      byteIdx  <= 2'h0;
      readMode <= 1'b0;
      regPtr   <= 8'h00;
      wrAddr   <= 8'h00;
      wrData   <= 8'h00;
      sdaOe    <= 1'b0;
      sclPrev  <= 1'b1;
      sdaPrev  <= 1'b1;
    end
    else if (!portEnable)
    begin
      // traffic during configuration is dropped without acknowledge
      state <= S_IDLE;
      sdaOe <= 1'b0;
    end
    else if (startSeen)
    begin
      state   <= S_RX;
      bitCnt  <= 4'h0;
      byteIdx <= 2'h0;
      sdaOe   <= 1'b0;
    end
    else if (stopSeen)
    begin
      state <= S_IDLE;
      sdaOe <= 1'b0;
    end
    else
    begin
      case (state)
        S_IDLE:
        begin
          sdaOe <= 1'b0;
        end
        S_RX:
        begin
          if (sclRise)
          begin
            shiftReg <= {shiftReg[6:0], sdaSync};
            bitCnt   <= bitCnt + 4'h1;
          end
          else if (sclFall && bitCnt == 4'h8)
          begin
            bitCnt <= 4'h0;
            if (byteIdx == 2'h0 && shiftReg[7:1] != `DPC_TARGET_ADDR)
              state <= S_IDLE; // not ours, stay silent
            else
            begin
              state <= S_ACK;
              sdaOe <= 1'b1;
              if (byteIdx == 2'h0)
                readMode <= shiftReg[0];
              else if (byteIdx == 2'h1)
                regPtr <= shiftReg;
              else
              begin
                wrStrobe <= 1'b1;
                wrAddr   <= regPtr;
                wrData   <= shiftReg;
                regPtr   <= regPtr + 8'h01; // auto-increment
              end
            end
          end
        end
        S_ACK:
        begin
          if (sclFall)
          begin
            if (byteIdx != 2'h2)
              byteIdx <= byteIdx + 2'h1;
            if (readMode && byteIdx == 2'h0)
            begin
              state    <= S_TX;
              shiftReg <= rdData;
              sdaOe    <= ~rdData[7];
              regPtr   <= regPtr + 8'h01;
            end
            else
            begin
              state <= S_RX;
              sdaOe <= 1'b0;
            end
          end
        end
        S_TX:
        begin
          if (sclFall)
          begin
            if (bitCnt == 4'h7)
            begin
              state <= S_TXACK;
              sdaOe <= 1'b0;
            end
            else
            begin
              shiftReg <= {shiftReg[6:0], 1'b0};
              sdaOe    <= ~shiftReg[6];
              bitCnt   <= bitCnt + 4'h1;
            end
          end
        end
        S_TXACK:
        begin
          // a missing acknowledge ends the read burst
          if (sclRise && sdaSync)
            state <= S_IDLE;
          else if (sclFall)
          begin
            state    <= S_TX;
            bitCnt   <= 4'h0;
            shiftReg <= rdData;
            sdaOe    <= ~rdData[7];
            regPtr   <= regPtr + 8'h01;
          end
        end
        default:
        begin
          state <= S_IDLE;
          sdaOe <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// File: src/dpc_panel_sequencer.v
`default_nettype none
`include "dpc_map.vh"

// What this block does
// - After io, core and serial rails are good, load defaults up to 100 ms, ignore serial port.
// - After loading, serial port accepts writes; turn-on waits for seen video; host waits.
// - After the turn-on command completes, the panel displays images.
// - A value written to a control register acts on the display.
module dpc_panel_sequencer
#(
  parameter integer CONFIG_LOAD_CYC = `DPC_CONFIG_LOAD_CYC,
  parameter integer REG_COUNT       = `DPC_REG_COUNT
)
(
  // clock and reset
  input  wire       sys_clk,
  input  wire       srst,
  // supply good levels from the pins
  input  wire       ioRailGood,
  input  wire       coreRailGood,
  input  wire       serialRailGood,
  input  wire       analogRailGood,
  // video frame sync pin
  input  wire       frameSync,
  // two-wire serial pins
  input  wire       sclPin,
  input  wire       sdaIn,
  output reg        sdaOut,
  output wire       sdaOe,
  // panel state
  output reg        configBusy,
  output reg        serialActive,
  output reg        displayOn,
  output reg        videoSeen,
  output reg  [5:0] panelState,
  // control register contents
  output reg  [7:0] ctrlReg0,
  output reg  [7:0] ctrlReg1
);

  localparam [5:0] P_OFF     = 6'h01;
  localparam [5:0] P_LOAD    = 6'h02;
  localparam [5:0] P_READY   = 6'h04;
  localparam [5:0] P_ARMED   = 6'h08;
  localparam [5:0] P_DISPLAY = 6'h10;
  localparam [5:0] P_SLEEP   = 6'h20;

  reg  [7:0]  cfgMem [0:REG_COUNT-1];
  reg  [23:0] loadTimer;
  reg  [7:0]  loadIdx;
  reg  [5:0]  next_state;
  reg  [5:0]  pinMeta;
  reg  [5:0]  pinSync;
  reg         fsMeta;
  reg         fsSync;
  reg         fsPrev;
  reg  [7:0]  rdData;
  // low-voltage rails only; the analog rail may drop in sleep
  wire        railsUp = pinSync[0] & pinSync[1] & pinSync[2];
  wire        wrStrobe;
  wire [7:0]  wrAddr;
  wire [7:0]  wrData;
  wire [7:0]  rdAddr;
  wire        cmdWrite = wrStrobe && wrAddr == `DPC_REG_CMD;

  // defaults held in non-volatile store
  function [7:0] defaultValue;
    input [7:0] idx;
    begin
      defaultValue = (idx == 8'h00) ? `DPC_DFLT_REG0 : `DPC_DFLT_OTHER;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers for the rail and serial pins
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      pinMeta <= 6'h30; // serial lines idle high: no false edge after reset
      pinSync <= 6'h30;
      fsPrev  <= 1'b0;
    end
    else
    begin
      // each rail synchronised alone; gating two pins ahead of the flop could glitch
      pinMeta <= {sdaIn, sclPin, analogRailGood, serialRailGood, ioRailGood, coreRailGood};
      pinSync <= pinMeta;
      fsPrev  <= fsSync;
    end
  end

  // frame sync gets its own pair; it is not a rail
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      fsMeta <= 1'b0;
      fsSync <= 1'b0;
    end
    else
    begin
      fsMeta <= frameSync;
      fsSync <= fsMeta;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // serial target, shut off while configuration loads
  dpc_serial_target u_target
  (
    .sys_clk    (sys_clk),
    .srst       (srst),
    .sclSync    (pinSync[4]),
    .sdaSync    (pinSync[5]),
    .portEnable (serialActive),
    .rdData     (rdData),
    .rdAddr     (rdAddr),
    .wrStrobe   (wrStrobe),
    .wrAddr     (wrAddr),
    .wrData     (wrData),
    .sdaOe      (sdaOe)
  );

  // read mux: config bytes, then status
  always @*
  begin
    if (rdAddr < REG_COUNT)
      rdData = cfgMem[rdAddr[2:0]];
    else if (rdAddr == `DPC_REG_STATUS)
      rdData = {2'b00, panelState};
    else
      rdData = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////
  // power and command state machine
  always @*
  begin
    next_state = panelState;
    case (panelState)
      P_OFF:
        if (railsUp)
          next_state = P_LOAD;
      P_LOAD:
        if (loadTimer == CONFIG_LOAD_CYC[23:0] - 24'h000001)
          next_state = P_READY;
      P_READY:
        // turn-on waits for seen video; refused otherwise
        if (cmdWrite && wrData == `DPC_CMD_ON_START && videoSeen)
          next_state = P_ARMED;
      P_ARMED:
        if (cmdWrite && wrData == `DPC_CMD_ON_FINAL && pinSync[3])
          next_state = P_DISPLAY;
        else if (cmdWrite && wrData == `DPC_CMD_OFF)
          next_state = P_READY;
      P_DISPLAY:
        if (cmdWrite && wrData == `DPC_CMD_OFF)
          next_state = P_READY;
        else if (cmdWrite && wrData == `DPC_CMD_SLEEP)
          next_state = P_SLEEP;
      P_SLEEP:
        if (cmdWrite && wrData == `DPC_CMD_WAKE)
          next_state = P_ARMED;
        else if (cmdWrite && wrData == `DPC_CMD_OFF)
          next_state = P_READY;
      default:
        next_state = P_OFF;
    endcase
    // losing any low-voltage rail drops straight to off
    if (!railsUp)
      next_state = P_OFF;
  end

  ////////////////////////////////////////////////////////////////////////
  // state, load timer and status flags
  always @(posedge sys_clk)
  begin
    sdaOut <= 1'b0; // open drain: only ever pulls low
    if (srst)
    begin
      panelState   <= P_OFF;
      loadTimer    <= 24'h000000;
      loadIdx      <= 8'h00;
      configBusy   <= 1'b0;
      serialActive <= 1'b0;
      displayOn    <= 1'b0;
      videoSeen    <= 1'b0;
    end
    else
    begin
      panelState   <= next_state;
      configBusy   <= next_state == P_LOAD;
      serialActive <= next_state != P_OFF && next_state != P_LOAD;
      displayOn    <= next_state == P_DISPLAY;
      if (panelState == P_LOAD)
        loadTimer <= loadTimer + 24'h000001;
      else
        loadTimer <= 24'h000000;
      if (panelState == P_LOAD && loadIdx < REG_COUNT)
        loadIdx <= loadIdx + 8'h01;
      else if (panelState == P_OFF)
        loadIdx <= 8'h00;
      // any rising frame-sync edge with rails up counts as video present
      if (!railsUp)
        videoSeen <= 1'b0;
      else if (fsSync && !fsPrev)
        videoSeen <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // working memory: default copy during load, then host writes
  always @(posedge sys_clk)
  begin
    if (srst)
    begin
      ctrlReg0 <= `DPC_DFLT_REG0;
      ctrlReg1 <= `DPC_DFLT_OTHER;
    end
    else if (panelState == P_LOAD && loadIdx < REG_COUNT)
    begin
      cfgMem[loadIdx[2:0]] <= defaultValue(loadIdx);
      if (loadIdx == 8'h00)
        ctrlReg0 <= defaultValue(loadIdx);
      if (loadIdx == 8'h01)
        ctrlReg1 <= defaultValue(loadIdx);
    end
    else if (wrStrobe && wrAddr < REG_COUNT)
    begin
      // values written to registers 0 and 1 drive the display path at once
      cfgMem[wrAddr[2:0]] <= wrData;
      if (wrAddr == 8'h00)
        ctrlReg0 <= wrData;
      if (wrAddr == 8'h01)
        ctrlReg1 <= wrData;
    end
  end

endmodule
`default_nettype wire

// File: tb/dpc_panel_sequencer_sva.sv
`default_nettype none
module dpc_panel_sequencer_sva
#(
  parameter integer CONFIG_LOAD_CYC = 200
)
(
  // clock and reset
  input wire logic       sys_clk,
  input wire logic       srst,
  // rails
  input wire logic       ioRailGood,
  input wire logic       analogRailGood,
  // panel outputs
  input wire logic       sdaOe,
  input wire logic       configBusy,
  input wire logic       serialActive,
  input wire logic       displayOn,
  input wire logic [5:0] panelState
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] loadCnt;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////
  // cycles spent loading; a stuck counter in the design would overrun it
  always_ff @(posedge sys_clk)
    loadCnt <= panelState[1] ? loadCnt + 32'h1 : 32'h0;
  ////////////////////////////////////////
  one_hot_a: assert property ($onehot(panelState))
    else $error("state not one-hot");
  load_bound_a: assert property (panelState[1] |-> loadCnt <= CONFIG_LOAD_CYC + 3)
    else $error("load too long");
  load_full_a: assert property ($rose(panelState[2]) && $past(panelState[1])
    |-> loadCnt >= CONFIG_LOAD_CYC - 1) else $error("load too short");
  quiet_load_a: assert property (panelState[1] && $past(panelState[1])
    |-> !sdaOe && !serialActive) else $error("serial port active in load");
  busy_follow_a: assert property ($rose(panelState[1]) |=> configBusy)
    else $error("busy flag late");
  ack_active_a: assert property ($rose(sdaOe) |-> serialActive)
    else $error("answer while port inactive");
  final_step_a: assert property ($rose(panelState[4])
    |-> $past(panelState[3]) && $past(analogRailGood, 3)) else $error("bad display entry");
  display_lag_a: assert property (displayOn == panelState[4])
    else $error("display flag off state");
  rail_drop_a: assert property ($fell(ioRailGood) |-> ##[1:4] panelState == 6'h01)
    else $error("no off after rail loss");
endmodule
bind dpc_panel_sequencer dpc_panel_sequencer_sva #(.CONFIG_LOAD_CYC(CONFIG_LOAD_CYC))
  i_dpc_panel_sequencer_sva (.sys_clk(sys_clk), .srst(srst), .ioRailGood(ioRailGood),
  .analogRailGood(analogRailGood), .sdaOe(sdaOe), .configBusy(configBusy),
  .serialActive(serialActive), .displayOn(displayOn), .panelState(panelState));
`default_nettype wire

// File: tb/dpc_host_model.sv
`default_nettype none
`include "dpc_map.vh"
module dpc_host_model
#(
  parameter integer MS_CYC    = 20,
  parameter integer FIELD_CYC = 40
)
(
  // clock and panel data drive
  input  wire logic sys_clk,
  input  wire logic sdaOe,
  // supplies, video and serial lines
  output var  logic ioRailGood,
  output var  logic coreRailGood,
  output var  logic serialRailGood,
  output var  logic analogRailGood,
  output var  logic frameSync,
  output var  logic sclPin,
  output wire logic sdaIn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic videoOn;
  logic hostLow;
  int   fieldCnt;
  ////////////////////////////////////////
  // open drain with pull-up: high unless someone pulls low
  assign sdaIn = !(hostLow || sdaOe);
  // idle levels; the serial clock stands high outside frames
  initial
  begin
    {ioRailGood, coreRailGood, serialRailGood, analogRailGood} = 4'h0;
    {videoOn, hostLow, frameSync, sclPin} = 4'h1;
    fieldCnt = 0;
  end
  // one sync pulse a field while video runs
  initial
  forever
  begin
    repeat (FIELD_CYC - 2) @(negedge sys_clk);
    frameSync = videoOn;
    repeat (2) @(negedge sys_clk);
    frameSync = 1'b0;
  end
  // fields counted on sync edges
  always @(posedge frameSync)
    fieldCnt++;
  ////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task automatic sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      wt(2);
      hostLow = !b[i];
      wt(2);
      sclPin = 1'b1;
      wt(4);
      sclPin = 1'b0;
    end
    wt(2);
    hostLow = 1'b0;
    wt(2);
    sclPin = 1'b1;
    wt(3);
    ack = sdaIn;
    wt(1);
    sclPin = 1'b0;
  endtask
  // start, target address, pointer, data; stop early on a refused address
  task automatic writeReg(input logic [7:0] ptr, d0, d1, input bit two, output logic ack);
    logic a;
    wt(4);
    hostLow = 1'b1;
    wt(4);
    sclPin = 1'b0;
    sendByte({`DPC_TARGET_ADDR, 1'b0}, ack);
    if (ack === 1'b0)
    begin
      sendByte(ptr, a);
      sendByte(d0, a);
      if (two)
        sendByte(d1, a);
    end
    wt(2);
    hostLow = 1'b1;
    wt(2);
    sclPin = 1'b1;
    wt(4);
    hostLow = 1'b0;
  endtask
  task automatic powerUp();
    ioRailGood = 1'b1;
    wt(MS_CYC);
    serialRailGood = 1'b1;
    wt(MS_CYC / 2);
    coreRailGood = 1'b1;
    wt(2);
  endtask
  // video after the rails; pixel valid is not modelled, so it stands tied low
  task automatic videoUp();
    videoOn = 1'b1;
  endtask
  task automatic analogOn();
    int f0;
    f0 = fieldCnt;
    while (fieldCnt < f0 + 6)
      wt(1);
    analogRailGood = 1'b1;
    wt(4);
  endtask
  // hold covers the wait inside the off command too
  task automatic analogOff();
    wt(3 * MS_CYC);
    analogRailGood = 1'b0;
  endtask
  task automatic powerDown();
    analogOff();
    videoOn = 1'b0;
    wt(MS_CYC / 5 + 1);
    {ioRailGood, coreRailGood, serialRailGood} = 3'h0;
  endtask
endmodule
`default_nettype wire

// File: tb/dpc_panel_sequencer_tb.sv
`default_nettype none
`include "dpc_map.vh"
module dpc_panel_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       sys_clk;
  logic       srst;
  wire logic  ioRailGood, coreRailGood, serialRailGood, analogRailGood;
  wire logic  frameSync, sclPin, sdaIn, sdaOut, sdaOe;
  wire logic  configBusy, serialActive, displayOn, videoSeen;
  wire logic  [5:0] panelState;
  wire logic  [7:0] ctrlReg0, ctrlReg1;
  logic [5:0] expQ[$];
  int         bad_count = 0;
  int         compares = 0;
  int         cycles = 0;
  dpc_panel_sequencer #(.CONFIG_LOAD_CYC(200)) i_dpc_panel_sequencer (.sys_clk(sys_clk),
    .srst(srst), .ioRailGood(ioRailGood), .coreRailGood(coreRailGood),
    .serialRailGood(serialRailGood), .analogRailGood(analogRailGood), .frameSync(frameSync),
    .sclPin(sclPin), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .configBusy(configBusy),
    .serialActive(serialActive), .displayOn(displayOn), .videoSeen(videoSeen),
    .panelState(panelState), .ctrlReg0(ctrlReg0), .ctrlReg1(ctrlReg1));
  dpc_host_model i_dpc_host_model (.sys_clk(sys_clk), .sdaOe(sdaOe), .ioRailGood(ioRailGood),
    .coreRailGood(coreRailGood), .serialRailGood(serialRailGood), .sdaIn(sdaIn),
    .analogRailGood(analogRailGood), .frameSync(frameSync), .sclPin(sclPin));
  ////////////////////////////////////////
  task automatic check(input string what, input logic [7:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic cmd(input logic [7:0] c);
    logic a;
    i_dpc_host_model.writeReg(`DPC_REG_CMD, c, 8'h00, 1'b0, a);
    repeat (4) @(negedge sys_clk);
  endtask
  ////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  // hang guard: the whole run needs well under this
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      bad_count++;
      print_verdict();
    end
  end
  // each state move is matched against the oldest expected state
  initial
  forever
  begin
    @(panelState);
    if (!srst)
      check("state", {2'h0, panelState}, expQ.size() ? {2'h0, expQ.pop_front()} : 8'hFF);
  end
  ////////////////////////////////////////
  initial
  begin
    logic       ack;
    logic [7:0] r0, r1;
    logic [7:0] ign [5];
    srst = 1'b1;
    r0 = 8'($urandom(32'h4298));
    repeat (16) @(negedge sys_clk);
    srst = 1'b0;
    check("ctrlReg0", ctrlReg0, `DPC_DFLT_REG0);
    check("ctrlReg1", ctrlReg1, `DPC_DFLT_OTHER);
    $display("test reset done");
    // serial traffic is ignored while off and while loading
    i_dpc_host_model.writeReg(8'h00, 8'h5A, 8'h00, 1'b0, ack);
    check("ack off", 8'(ack), 8'h01);
    expQ.push_back(6'h02);
    expQ.push_back(6'h04);
    i_dpc_host_model.powerUp();
    i_dpc_host_model.writeReg(8'h00, 8'h5A, 8'h00, 1'b0, ack);
    check("ack load", 8'(ack), 8'h01);
    check("configBusy", 8'(configBusy), 8'h01);
    check("sdaOut", 8'(sdaOut), 8'h00);
    repeat (300) @(negedge sys_clk);
    check("serialActive", 8'(serialActive), 8'h01);
    check("configBusy done", 8'(configBusy), 8'h00);
    check("ctrlReg0 kept", ctrlReg0, `DPC_DFLT_REG0);
    $display("test load done");
    // auto-increment write of two random values
    r0 = 8'($urandom);
    r1 = 8'($urandom);
    i_dpc_host_model.writeReg(8'h00, r0, r1, 1'b1, ack);
    check("ack ready", 8'(ack), 8'h00);
    check("ctrlReg0", ctrlReg0, r0);
    check("ctrlReg1", ctrlReg1, r1);
    // every other command is ignored in ready, turn-on too while no field has been seen
    ign[0] = `DPC_CMD_SLEEP;
    ign[1] = `DPC_CMD_ON_START;
    ign[2] = `DPC_CMD_ON_FINAL;
    ign[3] = `DPC_CMD_OFF;
    ign[4] = `DPC_CMD_WAKE;
    foreach (ign[i])
      cmd(ign[i]);
    check("no video", 8'(videoSeen), 8'h00);
    check("ready kept", {2'h0, panelState}, 8'h04);
    i_dpc_host_model.videoUp();
    repeat (100) @(negedge sys_clk);
    check("video seen", 8'(videoSeen), 8'h01);
    $display("test ready done");
    expQ.push_back(6'h08);
    cmd(`DPC_CMD_ON_START);
    cmd(`DPC_CMD_ON_FINAL);
    check("armed kept", {2'h0, panelState}, 8'h08);
    i_dpc_host_model.analogOn();
    expQ.push_back(6'h10);
    cmd(`DPC_CMD_ON_FINAL);
    check("displayOn", 8'(displayOn), 8'h01);
    $display("test turn-on done");
    expQ.push_back(6'h20);
    cmd(`DPC_CMD_SLEEP);
    i_dpc_host_model.analogOff();
    check("display sleep", 8'(displayOn), 8'h00);
    expQ.push_back(6'h08);
    cmd(`DPC_CMD_WAKE);
    i_dpc_host_model.analogOn();
    expQ.push_back(6'h10);
    cmd(`DPC_CMD_ON_FINAL);
    $display("test sleep done");
    expQ.push_back(6'h04);
    cmd(`DPC_CMD_OFF);
    expQ.push_back(6'h01);
    i_dpc_host_model.powerDown();
    repeat (8) @(negedge sys_clk);
    check("pending", 8'(expQ.size()), 8'h00);
    $display("test shutdown done");
    print_verdict();
  end
endmodule
`default_nettype wire
